// ### logic/tcn_pkg.sv
// Purpose: constants shared by the timer/counter block
// Assumes: 32-bit Avalon-MM slave, word addressed
// Notes: all offsets are word indices
package tcn_pkg;
  // ***************
  // register map
  // ***************
  localparam int ADDR_W = 4;
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h1;
  localparam logic [3:0] REG_CLKCON = 4'h2;
  localparam logic [3:0] REG_T0CNT = 4'h3;
  localparam logic [3:0] REG_T1CNT = 4'h4;
  localparam logic [3:0] REG_TIMER2_CONTROL_REG = 4'h5;
  localparam logic [3:0] REG_TIMER2_MODE_REG = 4'h6;
  localparam logic [3:0] REG_T2CNT = 4'h7;
  localparam logic [3:0] REG_CAP = 4'h8;
  // ***************
  // field positions
  // ***************
  localparam int MODE_T0_LO = 0;
  localparam int MODE_T0_CS = 2;
  localparam int MODE_T0_GATE = 3;
  localparam int MODE_T1_LO = 4;
  localparam int MODE_T1_CS = 6;
  localparam int MODE_T1_GATE = 7;
  localparam int CTRL_RUN0 = 0;
  localparam int CTRL_OVF0 = 1;
  localparam int CTRL_RUN1 = 2;
  localparam int CTRL_OVF1 = 3;
  localparam int CK_FAST0 = 3;
  localparam int CK_FAST1 = 4;
  localparam int CK_FAST2 = 5;
  localparam int T2C_CAPNRL = 0;
  localparam int T2C_CS = 1;
  localparam int T2C_RUN = 2;
  localparam int T2C_EXEN = 3;
  localparam int T2C_TRANSMIT_CLOCK_SELECT = 4;
  localparam int T2C_RCLK = 5;
  localparam int T2C_EXF = 6;
  localparam int T2C_OVF = 7;
  localparam int T2M_DOWN_COUNT_ENABLE = 0;
  localparam int T2M_OE = 1;
  localparam int T2M_AUTOCLR = 3;
  // ***************
  // values
  // ***************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] DIV_LAST = 4'hb;
  localparam logic [1:0] TM_13BIT = 2'h0;
  localparam logic [1:0] TM_16BIT = 2'h1;
  localparam logic [1:0] TM_RELOAD8 = 2'h2;
  localparam logic [1:0] TM_SPLIT = 2'h3;
  localparam logic [4:0] LOW5_TOP = 5'h1f;
  localparam logic [7:0] BYTE_TOP = 8'hff;
  localparam logic [15:0] WORD_TOP = 16'hffff;
  typedef enum logic [2:0] {T2_CAPTURE, T2_RELOAD_UP, T2_UPDOWN, T2_BAUD, T2_CLKOUT} tcn_t2mode_t;
endpackage

// ### logic/tcn_tick_if.sv
// Purpose: time-base enables from the divider
// Assumes: single clock domain
// Notes: each tick is a one-cycle pulse
`timescale 1ns/10ps
interface tcn_tick_if;
  logic tick12;
  logic tick4;
  logic tick2;
  modport src (output tick12, output tick4, output tick2);
  modport snk (input tick12, input tick4, input tick2);
endinterface

// ### logic/tcn_prescale.sv
// Purpose: divide core clock into /12, /4 and /2 enables
// Assumes: core_clk single domain
// Notes: /4 ticks coincide with /12 ticks every third time
`timescale 1ns/10ps
module tcn_prescale (
  input wire logic core_clk,
  input wire logic rst,
  tcn_tick_if.src ticks
);
  logic [3:0] divCnt_r;
  logic [3:0] divCnt_nxt;

  assign divCnt_nxt = (divCnt_r == tcn_pkg::DIV_LAST) ? 4'h0 : divCnt_r + 4'h1;
  assign ticks.tick12 = (divCnt_r == tcn_pkg::DIV_LAST);
  assign ticks.tick4 = (divCnt_r[1:0] == 2'h3);
  assign ticks.tick2 = divCnt_r[0];

  always_ff @(posedge core_clk) begin
    if (rst) divCnt_r <= 4'h0;
    else divCnt_r <= divCnt_nxt;
  end
endmodule

// ### logic/tcn_pin_sync.sv
// Purpose: synchronise a pin and detect sampled falling edges
// Assumes: pin idles high
// Notes: falls need a high sample then a low sample
`timescale 1ns/10ps
module tcn_pin_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pinIn,
  input wire logic sampleEn,
  output logic level,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic sample_r;
  logic fall_r;

  assign level = sync_r;
  assign fall = fall_r;

  // only the second stage feeds the sampler
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      sample_r <= 1'b1;
      fall_r <= 1'b0;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      fall_r <= sampleEn & sample_r & ~sync_r;
      if (sampleEn) sample_r <= sync_r;
    end
  end

  AST_FALL_SPACING: assert property (@(posedge core_clk) disable iff (rst) fall_r |=> !fall_r [*3])
    else $error("falling edges recognised too close together");
endmodule

// ### logic/tcn_timers.sv
// Purpose: timer/counters 0, 1 and 2 behind an Avalon-MM slave
// Assumes: 10 MHz core_clk, synchronous active-high rst
// Notes: waitrequest drops one cycle after a request is seen
`timescale 1ns/10ps
module tcn_timers (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic countInput0,
  input wire logic countInput1,
  input wire logic gateInput0,
  input wire logic gateInput1,
  input wire logic timer2CountPin,
  input wire logic externalTriggerPin,
  output logic clockOutPin,
  output logic clockOutEn,
  output logic timer0Irq,
  output logic timer1Irq,
  output logic timer2Irq
);
  // ***************
  // state
  // ***************
  logic wait_r;
  logic [31:0] rdata_r;
  logic [7:0] modeReg_r;
  logic [7:0] clkCon_r;
  logic [7:0] timer2_control_reg_r;
  logic [7:0] timer2_mode_reg_r;
  logic run0_r, ovf0_r, run1_r, ovf1_r, external_flag_r, ovf2_r;
  logic [7:0] tl0_r, th0_r, tl1_r, th1_r;
  logic [15:0] t2_r, cap_r;
  logic cout_r, coutEn_r, irq0_r, irq1_r, irq2_r;
  logic [7:0] tl0_nxt, th0_nxt, tl1_nxt, th1_nxt;
  logic [15:0] t2_nxt, cap_nxt;
  logic ovf2Set, exf2Set, exf2Tog, coutTog;

  // ***************
  // helpers
  // ***************
  function automatic logic [16:0] stepPair(input logic [1:0] mode, input logic [7:0] lo, input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    unique case (mode)
      tcn_pkg::TM_13BIT: begin
        r[4:0] = lo[4:0] + 5'h01;
        if (lo[4:0] == tcn_pkg::LOW5_TOP) begin
          r[15:8] = hi + 8'h01;
          r[16] = (hi == tcn_pkg::BYTE_TOP);
        end
      end
      tcn_pkg::TM_16BIT: begin
        r[15:0] = {hi, lo} + 16'h0001;
        r[16] = ({hi, lo} == tcn_pkg::WORD_TOP);
      end
      tcn_pkg::TM_RELOAD8: begin
        r[7:0] = (lo == tcn_pkg::BYTE_TOP) ? hi : lo + 8'h01;
        r[16] = (lo == tcn_pkg::BYTE_TOP);
      end
      tcn_pkg::TM_SPLIT: begin
        r[7:0] = lo + 8'h01;
        r[16] = (lo == tcn_pkg::BYTE_TOP);
      end
    endcase
    return r;
  endfunction

  function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ***************
  // time base and pins
  // ***************
  tcn_tick_if ticks ();
  tcn_prescale u_prescale (.core_clk(core_clk), .rst(rst), .ticks(ticks));

  logic tick0, tick1, tick2;
  logic cnt0Fall, cnt1Fall, t2PinFall, trigFall, trigLevel, gate0Level, gate1Level;
  assign tick0 = clkCon_r[tcn_pkg::CK_FAST0] ? ticks.tick4 : ticks.tick12;
  assign tick1 = clkCon_r[tcn_pkg::CK_FAST1] ? ticks.tick4 : ticks.tick12;
  assign tick2 = clkCon_r[tcn_pkg::CK_FAST2] ? ticks.tick4 : ticks.tick12;

  tcn_pin_sync u_cnt0 (.core_clk(core_clk), .rst(rst), .pinIn(countInput0), .sampleEn(tick0),
    .level(), .fall(cnt0Fall));
  tcn_pin_sync u_cnt1 (.core_clk(core_clk), .rst(rst), .pinIn(countInput1), .sampleEn(tick1),
    .level(), .fall(cnt1Fall));
  tcn_pin_sync u_t2pin (.core_clk(core_clk), .rst(rst), .pinIn(timer2CountPin), .sampleEn(tick2),
    .level(), .fall(t2PinFall));
  tcn_pin_sync u_trig (.core_clk(core_clk), .rst(rst), .pinIn(externalTriggerPin), .sampleEn(tick2),
    .level(trigLevel), .fall(trigFall));
  tcn_pin_sync u_gate0 (.core_clk(core_clk), .rst(rst), .pinIn(gateInput0), .sampleEn(tick0),
    .level(gate0Level), .fall());
  tcn_pin_sync u_gate1 (.core_clk(core_clk), .rst(rst), .pinIn(gateInput1), .sampleEn(tick1),
    .level(gate1Level), .fall());

  // ***************
  // bus decode
  // ***************
  logic take, wrTake;
  logic wrMode, wrCtrl, wrClk, wrT0, wrT1, wrT2Con, wrT2Mod, wrT2, wrCap;
  logic [31:0] readWord;
  assign take = (avs_read | avs_write) & ~wait_r;
  assign wrTake = avs_write & ~wait_r;
  assign wrMode = wrTake & (avs_address == tcn_pkg::REG_MODE) & avs_byteenable[0];
  assign wrCtrl = wrTake & (avs_address == tcn_pkg::REG_CTRL) & avs_byteenable[0];
  assign wrClk = wrTake & (avs_address == tcn_pkg::REG_CLKCON) & avs_byteenable[0];
  assign wrT0 = wrTake & (avs_address == tcn_pkg::REG_T0CNT) & |avs_byteenable[1:0];
  assign wrT1 = wrTake & (avs_address == tcn_pkg::REG_T1CNT) & |avs_byteenable[1:0];
  assign wrT2Con = wrTake & (avs_address == tcn_pkg::REG_TIMER2_CONTROL_REG) & avs_byteenable[0];
  assign wrT2Mod = wrTake & (avs_address == tcn_pkg::REG_TIMER2_MODE_REG) & avs_byteenable[0];
  assign wrT2 = wrTake & (avs_address == tcn_pkg::REG_T2CNT) & |avs_byteenable[1:0];
  assign wrCap = wrTake & (avs_address == tcn_pkg::REG_CAP) & |avs_byteenable[1:0];

  assign readWord =
    (avs_address == tcn_pkg::REG_MODE) ? {24'h000000, modeReg_r} :
    (avs_address == tcn_pkg::REG_CTRL) ? {28'h0000000, ovf1_r, run1_r, ovf0_r, run0_r} :
    (avs_address == tcn_pkg::REG_CLKCON) ? {24'h000000, clkCon_r} :
    (avs_address == tcn_pkg::REG_T0CNT) ? {16'h0000, th0_r, tl0_r} :
    (avs_address == tcn_pkg::REG_T1CNT) ? {16'h0000, th1_r, tl1_r} :
    (avs_address == tcn_pkg::REG_TIMER2_CONTROL_REG) ? {24'h000000, ovf2_r, external_flag_r, timer2_control_reg_r[5:0]} :
    (avs_address == tcn_pkg::REG_TIMER2_MODE_REG) ? {24'h000000, timer2_mode_reg_r} :
    (avs_address == tcn_pkg::REG_T2CNT) ? {16'h0000, t2_r} :
    (avs_address == tcn_pkg::REG_CAP) ? {16'h0000, cap_r} : 32'h00000000;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h00000000;
    end else begin
      wait_r <= ~((avs_read | avs_write) & wait_r);
      if ((avs_read | avs_write) & wait_r) rdata_r <= readWord;
    end
  end
  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  // ***************
  // timers 0 and 1
  // ***************
  logic [1:0] t0Mode, t1Mode;
  logic split0, en0, en1, inc0, inc1, incHi0, hiOvf0;
  logic [16:0] step0, step1;
  assign t0Mode = modeReg_r[tcn_pkg::MODE_T0_LO +: 2];
  assign t1Mode = modeReg_r[tcn_pkg::MODE_T1_LO +: 2];
  assign split0 = (t0Mode == tcn_pkg::TM_SPLIT);
  assign en0 = run0_r & (~modeReg_r[tcn_pkg::MODE_T0_GATE] | gate0Level);
  // with timer 0 split, timer 1 loses its run bit and is stopped only by its own mode 3 or by its gate input
  assign en1 = (split0 | run1_r) & (~modeReg_r[tcn_pkg::MODE_T1_GATE] | gate1Level);
  assign inc0 = en0 & (modeReg_r[tcn_pkg::MODE_T0_CS] ? cnt0Fall : tick0);
  assign inc1 = en1 & (t1Mode != tcn_pkg::TM_SPLIT) & (modeReg_r[tcn_pkg::MODE_T1_CS] ? cnt1Fall : tick1);
  assign incHi0 = split0 & run1_r & tick0;
  assign hiOvf0 = incHi0 & (th0_r == tcn_pkg::BYTE_TOP);
  assign step0 = stepPair(t0Mode, tl0_r, th0_r);
  assign step1 = stepPair(t1Mode, tl1_r, th1_r);

  always_comb begin
    {th0_nxt, tl0_nxt} = {th0_r, tl0_r};
    {th1_nxt, tl1_nxt} = {th1_r, tl1_r};
    if (inc0) tl0_nxt = step0[7:0];
    if (inc0 & ~split0) th0_nxt = step0[15:8];
    if (incHi0) th0_nxt = th0_r + 8'h01;
    if (inc1) {th1_nxt, tl1_nxt} = step1[15:0];
    if (wrT0) {th0_nxt, tl0_nxt} = mergeLanes({th0_r, tl0_r}, avs_writedata[15:0], avs_byteenable[1:0]);
    if (wrT1) {th1_nxt, tl1_nxt} = mergeLanes({th1_r, tl1_r}, avs_writedata[15:0], avs_byteenable[1:0]);
  end

  logic set0, set1;
  assign set0 = inc0 & step0[16];
  assign set1 = split0 ? hiOvf0 : (inc1 & step1[16]);

  // ***************
  // timer 2
  // ***************
  tcn_pkg::tcn_t2mode_t t2Mode;
  logic baudSel, coutSel, t2Ev, extEv, t2Top, t2AtCap;
  assign baudSel = timer2_control_reg_r[tcn_pkg::T2C_TRANSMIT_CLOCK_SELECT] | timer2_control_reg_r[tcn_pkg::T2C_RCLK];
  assign coutSel = ~timer2_control_reg_r[tcn_pkg::T2C_CAPNRL] & timer2_mode_reg_r[tcn_pkg::T2M_OE];
  assign t2Mode = coutSel ? tcn_pkg::T2_CLKOUT : baudSel ? tcn_pkg::T2_BAUD :
    timer2_control_reg_r[tcn_pkg::T2C_CAPNRL] ? tcn_pkg::T2_CAPTURE :
    timer2_mode_reg_r[tcn_pkg::T2M_DOWN_COUNT_ENABLE] ? tcn_pkg::T2_UPDOWN : tcn_pkg::T2_RELOAD_UP;
  // clock-out counts at clock/2 so one toggle per rollover gives clock/(4*(65536-cap))
  assign t2Ev = timer2_control_reg_r[tcn_pkg::T2C_RUN] & ((t2Mode == tcn_pkg::T2_CLKOUT) ? ticks.tick2 :
    (timer2_control_reg_r[tcn_pkg::T2C_CS] ? t2PinFall : tick2));
  assign extEv = timer2_control_reg_r[tcn_pkg::T2C_EXEN] & trigFall;
  assign t2Top = (t2_r == tcn_pkg::WORD_TOP);
  assign t2AtCap = (t2_r == cap_r);

  always_comb begin
    t2_nxt = t2_r;
    cap_nxt = cap_r;
    ovf2Set = 1'b0;
    exf2Set = 1'b0;
    exf2Tog = 1'b0;
    coutTog = 1'b0;
    unique case (t2Mode)
      tcn_pkg::T2_CAPTURE: begin
        if (t2Ev) begin
          t2_nxt = t2_r + 16'h0001;
          ovf2Set = t2Top;
        end
        if (extEv) begin
          cap_nxt = t2_r;
          exf2Set = 1'b1;
          if (timer2_mode_reg_r[tcn_pkg::T2M_AUTOCLR]) t2_nxt = 16'h0000;
        end
      end
      tcn_pkg::T2_RELOAD_UP: begin
        if (t2Ev) begin
          t2_nxt = t2Top ? cap_r : t2_r + 16'h0001;
          ovf2Set = t2Top;
        end
        if (extEv) begin
          t2_nxt = cap_r;
          exf2Set = 1'b1;
        end
      end
      tcn_pkg::T2_UPDOWN: begin
        if (t2Ev & trigLevel) begin
          t2_nxt = t2Top ? cap_r : t2_r + 16'h0001;
          ovf2Set = t2Top;
          exf2Tog = t2Top;
        end else if (t2Ev) begin
          t2_nxt = t2AtCap ? tcn_pkg::WORD_TOP : t2_r - 16'h0001;
          ovf2Set = t2AtCap;
          exf2Tog = t2AtCap;
        end
      end
      tcn_pkg::T2_BAUD: begin
        if (t2Ev) t2_nxt = t2Top ? cap_r : t2_r + 16'h0001;
        exf2Set = extEv;
      end
      tcn_pkg::T2_CLKOUT: begin
        if (t2Ev) t2_nxt = t2Top ? cap_r : t2_r + 16'h0001;
        coutTog = t2Ev & t2Top;
      end
    endcase
    if (wrT2) t2_nxt = mergeLanes(t2_r, avs_writedata[15:0], avs_byteenable[1:0]);
    if (wrCap) cap_nxt = mergeLanes(cap_r, avs_writedata[15:0], avs_byteenable[1:0]);
  end

  // ***************
  // registers
  // ***************
  // flag set by hardware wins over a clearing write in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      modeReg_r <= tcn_pkg::RESET_BYTE;
      clkCon_r <= tcn_pkg::RESET_BYTE;
      timer2_control_reg_r <= tcn_pkg::RESET_BYTE;
      timer2_mode_reg_r <= tcn_pkg::RESET_BYTE;
      {run0_r, ovf0_r, run1_r, ovf1_r} <= 4'h0;
    end else begin
      if (wrMode) modeReg_r <= avs_writedata[7:0];
      if (wrClk) clkCon_r <= avs_writedata[7:0];
      if (wrT2Con) timer2_control_reg_r <= avs_writedata[7:0];
      if (wrT2Mod) timer2_mode_reg_r <= avs_writedata[7:0];
      if (wrCtrl) {run1_r, run0_r} <= {avs_writedata[tcn_pkg::CTRL_RUN1], avs_writedata[tcn_pkg::CTRL_RUN0]};
      ovf0_r <= set0 | (wrCtrl ? avs_writedata[tcn_pkg::CTRL_OVF0] : ovf0_r);
      ovf1_r <= set1 | (wrCtrl ? avs_writedata[tcn_pkg::CTRL_OVF1] : ovf1_r);
    end
  end

  logic exf2Base, ovf2Base;
  assign exf2Base = wrT2Con ? avs_writedata[tcn_pkg::T2C_EXF] : external_flag_r;
  assign ovf2Base = wrT2Con ? avs_writedata[tcn_pkg::T2C_OVF] : ovf2_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      {tl0_r, th0_r, tl1_r, th1_r} <= 32'h00000000;
      t2_r <= 16'h0000;
      cap_r <= 16'h0000;
      external_flag_r <= 1'b0;
      ovf2_r <= 1'b0;
      cout_r <= 1'b0;
      coutEn_r <= 1'b0;
      {irq0_r, irq1_r, irq2_r} <= 3'h0;
    end else begin
      {tl0_r, th0_r, tl1_r, th1_r} <= {tl0_nxt, th0_nxt, tl1_nxt, th1_nxt};
      t2_r <= t2_nxt;
      cap_r <= cap_nxt;
      external_flag_r <= exf2Set | (exf2Base ^ exf2Tog);
      ovf2_r <= ovf2Set | ovf2Base;
      cout_r <= (t2Mode == tcn_pkg::T2_CLKOUT) ? cout_r ^ coutTog : 1'b0;
      coutEn_r <= (t2Mode == tcn_pkg::T2_CLKOUT) & timer2_control_reg_r[tcn_pkg::T2C_RUN];
      irq0_r <= ovf0_r;
      irq1_r <= ovf1_r;
      irq2_r <= ovf2_r | (external_flag_r & (t2Mode != tcn_pkg::T2_UPDOWN));
    end
  end
  assign clockOutPin = cout_r;
  assign clockOutEn = coutEn_r;
  assign timer0Irq = irq0_r;
  assign timer1Irq = irq1_r;
  assign timer2Irq = irq2_r;

  // ***************
  // checks
  // ***************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_BUS_ANSWER: assert property ((avs_read | avs_write) & wait_r |=> !wait_r ##1 wait_r)
    else $error("bus answer not one cycle after request");
  AST_FAST_CLEARED: assert property ($fell(rst) |-> clkCon_r == 8'h00)
    else $error("fast selects not cleared by reset");
  AST_M0_CARRY: assert property (t0Mode == tcn_pkg::TM_13BIT && inc0 && tl0_r[4:0] == 5'h1f && !wrT0
    |=> th0_r == $past(th0_r) + 8'h01 && tl0_r[4:0] == 5'h00)
    else $error("mode 0 carry into high byte missing");
  AST_M1_ROLL: assert property (t0Mode == tcn_pkg::TM_16BIT && inc0 && {th0_r, tl0_r} == 16'hffff
    && !wrT0 && !wrCtrl |=> ovf0_r && {th0_r, tl0_r} == 16'h0000)
    else $error("mode 1 rollover did not flag");
  AST_M2_RELOAD: assert property (t0Mode == tcn_pkg::TM_RELOAD8 && inc0 && tl0_r == 8'hff && !wrT0
    |=> tl0_r == $past(th0_r) && $stable(th0_r))
    else $error("mode 2 reload wrong");
  AST_GATE_HOLD: assert property (!split0 && !en0 && !wrT0 |=> $stable({th0_r, tl0_r}))
    else $error("timer 0 moved while gated off");
  AST_T1_FROZEN: assert property (t1Mode == tcn_pkg::TM_SPLIT && !wrT1 |=> $stable({th1_r, tl1_r}))
    else $error("timer 1 moved in mode 3");
  AST_CAPTURE: assert property (t2Mode == tcn_pkg::T2_CAPTURE && extEv && !wrCap && !wrT2Con
    |=> cap_r == $past(t2_r) && external_flag_r)
    else $error("capture did not copy count");
  AST_CLKOUT_TOGGLE: assert property (t2Mode == tcn_pkg::T2_CLKOUT && t2Ev && t2Top && !wrT2Con && !wrT2
    |=> clockOutPin != $past(clockOutPin) && t2_r == $past(cap_r) && !$rose(ovf2_r))
    else $error("clock-out did not toggle on rollover");
endmodule

// ### verification/tcn_pin_model.sv
// Purpose: far side of the timers, the count, gate and trigger pins
// Assumes: every pin idles high
// Notes: levels held 30 cycles so a /12 sample sees each
`timescale 1ns/10ps
module tcn_pin_model (
  input wire logic core_clk,
  output logic [5:0] pins
);
  // order: count0, count1, gate0, gate1, timer2 clock, trigger
  initial pins = 6'h3f;
  // ***************
  // pin activity
  // ***************
  task automatic fall(input int k, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (30) @(posedge core_clk);
      pins[k] <= 1'b0;
      repeat (30) @(posedge core_clk);
      pins[k] <= 1'b1;
    end
  endtask
  task automatic level(input int k, input logic b);
    @(posedge core_clk);
    pins[k] <= b;
  endtask
endmodule

// ### verification/timer_counters_0_1_2_bench.sv
// Purpose: self-checking bench for the timer block
// Assumes: register map of tcn_pkg, pins idle high
// Notes: the mode tests stop the timers before reading so counts do not race
`timescale 1ns/10ps
module timer_counters_0_1_2_bench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] v;
  logic [31:0] rdat;
  logic wreq;
  logic [5:0] pins;
  logic ckOut;
  logic ckEn;
  logic pv;
  logic irq0;
  logic irq2;
  logic [15:0] r;
  logic [15:0] ld [3] = '{16'hffff, 16'hfffc, 16'h80ff};
  logic [12:0] ex [3] = '{13'h001c, 13'h0000, 13'h1010};
  int failures = 0;
  int cmp_count = 0;
  int seed = 90;
  int n;
  int e;
  tcn_pin_model u_pins (.core_clk(core_clk), .pins(pins));
  tcn_timers u_dut (.core_clk(core_clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'h3), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .countInput0(pins[0]), .countInput1(pins[1]), .gateInput0(pins[2]), .gateInput1(pins[3]),
    .timer2CountPin(pins[4]), .externalTriggerPin(pins[5]), .clockOutPin(ckOut), .clockOutEn(ckEn),
    .timer0Irq(irq0), .timer1Irq(), .timer2Irq(irq2));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // ***************
  // tasks
  // ***************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // request held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    adr <= a;
    wd <= d;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge core_clk);
      k++;
    end while (wreq !== 1'b0 && k < 40);
    v = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 40) begin
      failures++;
      test_done();
    end
    @(posedge core_clk);
  endtask
  task automatic wt(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdr(input logic [3:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // ***************
  // scenarios
  // ***************
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    for (int a = 0; a < 10; a++) begin
      rdr(a[3:0]);
      chk(v, 32'h0);
    end
    $display("reset values done");
    wt(tcn_pkg::REG_CLKCON, 32'h18);
    for (int m = 0; m < 3; m++) begin
      wt(tcn_pkg::REG_MODE, m);
      wt(tcn_pkg::REG_T0CNT, ld[m]);
      wt(tcn_pkg::REG_CTRL, 32'h1);
      repeat (20) @(posedge core_clk);
      rdr(tcn_pkg::REG_CTRL);
      chk(v[1], 1'b1);
      chk(irq0, 1'b1);
      wt(tcn_pkg::REG_CTRL, 32'h0);
      rdr(tcn_pkg::REG_T0CNT);
      chk(v[15:3], ex[m]);
    end
    rdr(tcn_pkg::REG_CTRL);
    chk(v, 32'h0);
    wt(tcn_pkg::REG_MODE, 32'h3);
    wt(tcn_pkg::REG_T0CNT, 32'h0);
    wt(tcn_pkg::REG_CTRL, 32'h4);
    repeat (20) @(posedge core_clk);
    wt(tcn_pkg::REG_CTRL, 32'h0);
    rdr(tcn_pkg::REG_T0CNT);
    chk(v[7:0], 8'h0);
    chk(v[15:8] != 8'h0, 1'b1);
    $display("modes done");
    wt(tcn_pkg::REG_MODE, 32'h9);
    // the split-mode run left a count in the high byte
    wt(tcn_pkg::REG_T0CNT, 32'h0);
    u_pins.level(2, 1'b0);
    wt(tcn_pkg::REG_CTRL, 32'h1);
    repeat (40) @(posedge core_clk);
    rdr(tcn_pkg::REG_T0CNT);
    chk(v, 32'h0);
    u_pins.level(2, 1'b1);
    repeat (40) @(posedge core_clk);
    rdr(tcn_pkg::REG_T0CNT);
    chk(v[15:0] != 16'h0, 1'b1);
    for (int k = 0; k < 2; k++) begin
      r = 16'($random(seed));
      wt(tcn_pkg::REG_MODE, k ? 32'h50 : 32'h05);
      wt(4'(tcn_pkg::REG_T0CNT + k), r);
      wt(tcn_pkg::REG_CTRL, k ? 32'h4 : 32'h1);
      u_pins.fall(k, 3);
      repeat (10) @(posedge core_clk);
      rdr(4'(tcn_pkg::REG_T0CNT + k));
      chk(v[15:0], 16'(r + 16'h3));
    end
    $display("gate and counter done");
    wt(tcn_pkg::REG_T2CNT, r);
    wt(tcn_pkg::REG_TIMER2_MODE_REG, 32'h8);
    wt(tcn_pkg::REG_TIMER2_CONTROL_REG, 32'h0f);
    u_pins.fall(5, 1);
    repeat (10) @(posedge core_clk);
    rdr(tcn_pkg::REG_CAP);
    chk(v[15:0], r);
    rdr(tcn_pkg::REG_TIMER2_CONTROL_REG);
    chk(v[7:0], 8'h4f);
    rdr(tcn_pkg::REG_T2CNT);
    chk(v[15:0], 16'h0);
    wt(tcn_pkg::REG_TIMER2_MODE_REG, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wt(tcn_pkg::REG_TIMER2_CONTROL_REG, k ? 32'h16 : 32'h06);
      wt(tcn_pkg::REG_T2CNT, 32'hffff);
      u_pins.fall(4, 1);
      repeat (10) @(posedge core_clk);
      rdr(tcn_pkg::REG_T2CNT);
      chk(v[15:0], r);
      rdr(tcn_pkg::REG_TIMER2_CONTROL_REG);
      chk(v[7], k == 0);
    end
    $display("timer 2 reload done");
    wt(tcn_pkg::REG_CAP, 32'hfffe);
    // start at the reload value, a random count could take too long to roll
    wt(tcn_pkg::REG_T2CNT, 32'hfffe);
    wt(tcn_pkg::REG_TIMER2_MODE_REG, 32'h2);
    wt(tcn_pkg::REG_TIMER2_CONTROL_REG, 32'h4);
    repeat (10) @(posedge core_clk);
    n = 0;
    e = 0;
    pv = ckOut;
    for (int i = 0; i < 160; i++) begin
      @(posedge core_clk);
      n += int'(ckOut !== pv);
      e += int'(ckOut === 1'b1);
      pv = ckOut;
    end
    chk(n, 2 * 160 / (4 * (65536 - 65534)));
    chk(e, 80);
    chk(ckEn, 1'b1);
    chk(irq2, 1'b0);
    $display("clock out done");
    test_done();
  end
endmodule
